// ### data_space_map_decoder.v
// Contract
// (RULE1) With the program-map select bit set, block zero decodes in program space.
// (RULE2) With the bit clear, block zero decodes in local data space only.
// (RULE3) Reset clears the program-map select bit.
// (RULE4) Shared-ram enable high maps the preset range in both spaces to one ram.
// (RULE5) Shared-ram enable low sends both preset ranges to external memory separately.
// (RULE6) Only upper-half data addresses may be global.
// (RULE7) The size register is eight bits on the low data lines at data address 0005h.
// (RULE8) The low byte sizes the region; zero means none, each leading one halves it.
// (RULE9) Upper-half addresses outside the region stay local.
// (RULE10) The data-space strobe goes low on every data access.
// (RULE11) The global strobe goes low on accesses inside the global region.
// (RULE12) Software writes only the listed leading-ones patterns.
// (RULE13) The upper byte of a write is ignored.
// (RULE14) A separate 64K-word I/O space exists beside program and data.
// (RULE15) The size register is read and written with no wait states.
// (RULE16) Global means upper byte AND size equals size with size nonzero.
`timescale 1ns/1ns
`include "map_decoder_defines.vh"
module data_space_map_decoder #(
    parameter [15:0] ZERO_DATA_BASE = `BLOCK_ZERO_DATA_BASE,
    parameter [15:0] ZERO_PROG_BASE = `BLOCK_ZERO_PROG_BASE,
    parameter [15:0] ZERO_WORDS = `BLOCK_ZERO_WORDS,
    parameter [15:0] SHARED_BASE = `SHARED_RAM_BASE,
    parameter [15:0] SHARED_WORDS = `SHARED_RAM_WORDS
) (
    // clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // status word one write from the core
    input wire i_status_wr,
    input wire [15:0] i_status_wdata,
    // shared-ram enable pin
    input wire i_shared_ram_enable,
    // data access
    input wire i_data_access,
    input wire i_data_wr,
    input wire [15:0] i_data_addr,
    input wire [15:0] i_data_wdata,
    // program access
    input wire i_prog_access,
    input wire [15:0] i_prog_addr,
    // i/o access
    input wire i_io_access,
    input wire [15:0] i_io_addr,
    // register read back and status
    output reg [15:0] o_reg_rdata,
    output reg o_reg_hit,
    output reg [15:0] o_status_word_one,
    output reg o_program_map_select,
    // data decode
    output reg o_data_space_strobe_n,
    output reg o_global_access_strobe_n,
    output reg o_data_block_zero,
    output reg o_data_shared,
    output reg o_data_ext,
    // program decode
    output reg o_prog_block_zero,
    output reg o_prog_shared,
    output reg o_prog_ext,
    // i/o decode
    output reg o_io_strobe_n,
    output reg [15:0] o_io_addr
);
    reg ram_en_meta_q;
    reg ram_en_q;
    wire [7:0] size_byte;
    wire [7:0] size_rdata;
    wire size_wr;
    wire map_sel;
    wire data_global;
    wire d_blk0;
    wire d_sa;
    wire p_blk0;
    wire p_sa;

    // true when addr lies in [base, base+words)
    function in_window;
        input [15:0] addr;
        input [15:0] base;
        input [15:0] words;
        reg [16:0] top;
        begin
            top = {1'b0, base} + {1'b0, words};
            in_window = ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
        end
    endfunction

    // pin passes two flops before decode reads it
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ram_en_meta_q <= 1'b0;
            ram_en_q <= 1'b0;
        end else begin
            ram_en_meta_q <= i_shared_ram_enable;
            ram_en_q <= ram_en_meta_q;
        end
    end

    // status word one, select bit cleared at reset
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_status_word_one <= `STATUS_WORD_ONE_RST; // (RULE3)
        end else if (i_status_wr) begin
            o_status_word_one <= i_status_wdata;
        end
    end
    assign map_sel = o_status_word_one[`PROGRAM_MAP_SELECT_BIT];

    // size register lives on the low byte at its data address
    assign size_wr = i_data_access && i_data_wr && (i_data_addr == `GLOBAL_REGION_SIZE_ADDR); // (RULE7)

    global_region_reg u_size_reg (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_wr(size_wr),
        .i_wdata(i_data_wdata[7:0]),
        .o_size(size_byte),
        .o_rdata(size_rdata)
    );

    // mask compare, gated by data address bit 15 so only upper half hits
    assign data_global = (size_byte != 8'h00) && // (RULE8)
        ((i_data_addr[15:8] & size_byte) == size_byte) && // (RULE16)
        i_data_addr[`UPPER_HALF_BIT]; // (RULE6)

    // window decode
    assign d_blk0 = !map_sel && in_window(i_data_addr, ZERO_DATA_BASE, ZERO_WORDS); // (RULE2)
    assign p_blk0 = map_sel && in_window(i_prog_addr, ZERO_PROG_BASE, ZERO_WORDS); // (RULE1)
    assign d_sa = ram_en_q && in_window(i_data_addr, SHARED_BASE, SHARED_WORDS); // (RULE4)
    assign p_sa = ram_en_q && in_window(i_prog_addr, SHARED_BASE, SHARED_WORDS); // (RULE4)

    // registered decode outputs; one cycle behind the request
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_data_space_strobe_n <= 1'b1;
            o_global_access_strobe_n <= 1'b1;
            o_data_block_zero <= 1'b0;
            o_data_shared <= 1'b0;
            o_data_ext <= 1'b0;
            o_prog_block_zero <= 1'b0;
            o_prog_shared <= 1'b0;
            o_prog_ext <= 1'b0;
            o_io_strobe_n <= 1'b1;
            o_io_addr <= 16'h0000;
            o_reg_hit <= 1'b0;
            o_program_map_select <= 1'b0;
        end else begin
            o_data_space_strobe_n <= !i_data_access; // (RULE10)
            o_global_access_strobe_n <= !(i_data_access && data_global); // (RULE11)
            // upper-half addresses outside the region fall through as local
            o_data_block_zero <= i_data_access && d_blk0; // (RULE9)
            o_data_shared <= i_data_access && d_sa;
            // with ram off the preset range falls through to external
            o_data_ext <= i_data_access && !d_blk0 && !d_sa; // (RULE5)
            o_prog_block_zero <= i_prog_access && p_blk0;
            o_prog_shared <= i_prog_access && p_sa;
            o_prog_ext <= i_prog_access && !p_blk0 && !p_sa; // (RULE5)
            // i/o space is its own 64K map
            o_io_strobe_n <= !i_io_access; // (RULE14)
            o_io_addr <= i_io_addr; // (RULE14)
            o_reg_hit <= i_data_access && (i_data_addr == `GLOBAL_REGION_SIZE_ADDR);
            o_program_map_select <= map_sel;
        end
    end

    // read back: upper bits zero
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 16'h0000;
        end else begin
            o_reg_rdata <= {8'h00, size_rdata}; // (RULE15)
        end
    end
endmodule // data_space_map_decoder

// ### map_decoder_defines.vh
`ifndef MAP_DECODER_DEFINES_VH
`define MAP_DECODER_DEFINES_VH
// data address of the global-region size register
`define GLOBAL_REGION_SIZE_ADDR 16'h0005
// reset value of the global-region size register (no global region)
`define GLOBAL_REGION_SIZE_RST 8'h00
// program-map select bit position inside status word one
`define PROGRAM_MAP_SELECT_BIT 12
// status word one reset value
`define STATUS_WORD_ONE_RST 16'h0000
// default dual-access block zero window, program and data addresses
`define BLOCK_ZERO_DATA_BASE 16'h0200
`define BLOCK_ZERO_PROG_BASE 16'hff00
`define BLOCK_ZERO_WORDS 16'h0100
// default preset shared single-access ram window
`define SHARED_RAM_BASE 16'h0800
`define SHARED_RAM_WORDS 16'h0800
// upper half of data space starts here
`define UPPER_HALF_BIT 15
`endif

// ### global_region_reg.v
`timescale 1ns/1ns
`include "map_decoder_defines.vh"
// storage for the global-region size byte, read data registered
module global_region_reg (
    // clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // write and read
    input wire i_wr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_size,
    output reg [7:0] o_rdata
);
    // upper byte never arrives here, so it cannot steer decode
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_size <= `GLOBAL_REGION_SIZE_RST;
            o_rdata <= `GLOBAL_REGION_SIZE_RST;
        end else begin
            if (i_wr) begin
                o_size <= i_wdata; // (RULE13)
            end
            o_rdata <= i_wr ? i_wdata : o_size; // (RULE15)
        end
    end
endmodule // global_region_reg

// ### data_space_map_decoder_properties.sv
`timescale 1ns/1ns
module data_space_map_decoder_properties (
    input logic i_sys_clk, i_rst, i_status_wr, i_shared_ram_enable, i_data_access,
    input logic i_prog_access, i_io_access, o_reg_hit, o_program_map_select,
    input logic o_data_space_strobe_n, o_global_access_strobe_n, o_data_shared,
    input logic o_data_ext, o_prog_shared, o_io_strobe_n,
    input logic [15:0] i_status_wdata, i_data_addr, i_prog_addr, i_io_addr,
    input logic [15:0] o_reg_rdata, o_status_word_one, o_io_addr
);
    // default shared window 0800h-0fffh; pin needs 2 edges to pass its synchroniser, the checks hold it for 4
    wire d_sr = i_data_addr[15:11] == 5'h01;
    wire p_sr = i_prog_addr[15:11] == 5'h01;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    strobe_on_access_a: assert property (i_data_access |=> !o_data_space_strobe_n)
        else $error("data strobe missing");
    strobes_idle_a: assert property (!i_data_access |=> o_data_space_strobe_n && o_global_access_strobe_n)
        else $error("strobe without access");
    lower_half_local_a: assert property (!i_data_addr[15] |=> o_global_access_strobe_n)
        else $error("lower half marked global");
    size_reg_hit_a: assert property (i_data_access && i_data_addr == 16'h0005 |=> o_reg_hit)
        else $error("size register not hit");
    upper_byte_zero_a: assert property (o_reg_rdata[15:8] == 8'h00)
        else $error("size upper byte not zero");
    map_select_load_a: assert property (i_status_wr |-> ##2 o_program_map_select == $past(i_status_wdata[12], 2))
        else $error("map select not loaded");
    reset_clears_a: assert property (disable iff (1'b0) i_rst |=> o_status_word_one == 16'h0000)
        else $error("status word not cleared");
    shared_off_ext_a: assert property (!i_shared_ram_enable [*4] ##0 i_data_access && d_sr |=> o_data_ext && !o_data_shared)
        else $error("shared range not external");
    shared_on_ram_a: assert property (i_shared_ram_enable [*4] ##0 i_prog_access && p_sr |=> o_prog_shared)
        else $error("shared range not on chip");
    io_space_a: assert property (i_io_access |=> !o_io_strobe_n && o_io_addr == $past(i_io_addr))
        else $error("io decode wrong");
    cover property (i_data_access && i_data_addr[15] ##1 !o_global_access_strobe_n);
    cover property (i_status_wr && i_status_wdata[12]);
    cover property (i_shared_ram_enable && i_prog_access);
endmodule // data_space_map_decoder_properties
bind data_space_map_decoder data_space_map_decoder_properties chk (.*);

// ### ext_bus_model.sv
`timescale 1ns/1ns
// external bus side: counts cycles where both strobes are low
module ext_bus_model (
    input wire i_sys_clk,
    input wire i_rst,
    input wire i_data_strobe_n,
    input wire i_glob_n,
    output reg [7:0] o_glob_count
);
    // a global cycle only counts with the data strobe low too
    always @(posedge i_sys_clk) begin
        if (i_rst) o_glob_count <= 8'h00;
        else if (!i_data_strobe_n && !i_glob_n) o_glob_count <= o_glob_count + 8'h01;
    end
endmodule // ext_bus_model

// ### data_space_map_decoder_tb.sv
`timescale 1ns/1ns
module data_space_map_decoder_tb;
    reg i_sys_clk = 1'b0, i_rst = 1'b1, i_status_wr = 1'b0, i_shared_ram_enable = 1'b0;
    reg i_data_access = 1'b0, i_data_wr = 1'b0, i_prog_access = 1'b0, i_io_access = 1'b0;
    reg [15:0] i_status_wdata = 16'h0000, i_data_addr = 16'h0000, i_data_wdata = 16'h0000;
    reg [15:0] i_prog_addr = 16'h0000, i_io_addr = 16'h0000;
    wire [15:0] o_reg_rdata, o_status_word_one, o_io_addr;
    wire o_reg_hit, o_program_map_select, o_data_space_strobe_n, o_global_access_strobe_n;
    wire o_data_block_zero, o_data_shared, o_data_ext, o_prog_block_zero, o_prog_shared;
    wire o_prog_ext, o_io_strobe_n;
    wire [7:0] glob_count;
    integer err_count = 0, samples_checked = 0, i;
    reg [24:0] rows [0:6]; // {global strobe, size, address}
    data_space_map_decoder dut (.*);
    ext_bus_model ext (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_data_strobe_n(o_data_space_strobe_n),
        .i_glob_n(o_global_access_strobe_n), .o_glob_count(glob_count));
    initial forever #20 i_sys_clk = ~i_sys_clk;
    task chk(input [31:0] nm, input [15:0] seen, input [15:0] exp); begin
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    end endtask
    // k: 0 data read, 1 data write, 2 program plus io, 3 status word write
    task acc(input [1:0] k, input [15:0] a, input [15:0] d); begin
        @(negedge i_sys_clk);
        i_data_access = (k < 2'd2);
        i_data_wr = (k == 2'd1);
        i_prog_access = (k == 2'd2);
        i_io_access = (k == 2'd2);
        i_status_wr = (k == 2'd3);
        {i_data_addr, i_prog_addr, i_io_addr} = {a, a, a};
        {i_data_wdata, i_status_wdata} = {d, d};
        @(negedge i_sys_clk);
        {i_data_access, i_data_wr, i_prog_access, i_io_access, i_status_wr} = 5'h00;
    end endtask
    task end_sim; begin
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end endtask
    // generous bound: the whole sequence needs well under 100 cycles
    initial begin
        #100000;
        err_count = err_count + 1;
        end_sim;
    end
    initial begin
        // only the listed leading-ones size patterns are written
        rows[0] = {1'b1, 8'h00, 16'hffff};
        rows[1] = {1'b0, 8'h80, 16'h8000};
        rows[2] = {1'b1, 8'hc0, 16'hbfff};
        rows[3] = {1'b0, 8'he0, 16'he123};
        rows[4] = {1'b0, 8'hff, 16'hff00};
        rows[5] = {1'b1, 8'hff, 16'hfeff};
        rows[6] = {1'b1, 8'h80, 16'h7fff};
        repeat (2) @(negedge i_sys_clk);
        i_rst = 1'b0;
        chk("sw1", o_status_word_one, 16'h0000);
        // junk upper byte on every size write must not matter
        for (i = 0; i < 7; i = i + 1) begin
            acc(2'd1, 16'h0005, {8'ha5, rows[i][23:16]});
            chk("hit", {15'h0, o_reg_hit}, 16'h0001);
            acc(2'd0, rows[i][15:0], 16'h0000);
            chk("dstb", {15'h0, o_data_space_strobe_n}, 16'h0000);
            chk("glob", {15'h0, o_global_access_strobe_n}, {15'h0, rows[i][24]});
            chk("rd", o_reg_rdata, {8'h00, rows[i][23:16]});
        end
        chk("gcnt", {8'h00, glob_count}, 16'h0003);
        acc(2'd3, 16'h1000, 16'h1000);
        acc(2'd2, 16'hff00, 16'h0000);
        chk("pblk", {o_prog_block_zero, o_program_map_select}, 16'h0003);
        chk("io", o_io_addr, 16'hff00);
        acc(2'd0, 16'h0200, 16'h0000);
        chk("dblk", {15'h0, o_data_block_zero}, 16'h0000);
        acc(2'd3, 16'h0000, 16'h0000);
        acc(2'd0, 16'h0200, 16'h0000);
        chk("dblk", {15'h0, o_data_block_zero}, 16'h0001);
        acc(2'd2, 16'hff00, 16'h0000);
        chk("pblk", {15'h0, o_prog_block_zero}, 16'h0000);
        // pin passes a two-flop synchroniser, so let it settle first
        i_shared_ram_enable = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        acc(2'd2, 16'h0900, 16'h0000);
        chk("psr", {o_prog_shared, o_prog_ext}, 16'h0002);
        acc(2'd0, 16'h0900, 16'h0000);
        chk("dsr", {o_data_shared, o_data_ext}, 16'h0002);
        i_shared_ram_enable = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        acc(2'd0, 16'h0900, 16'h0000);
        chk("dext", {o_data_shared, o_data_ext}, 16'h0001);
        acc(2'd2, 16'h0900, 16'h0000);
        chk("pext", {o_prog_shared, o_prog_ext}, 16'h0001);
        end_sim;
    end
endmodule // data_space_map_decoder_tb
